// *** design/bpc_ctrl.sv ***
// Purpose: fetch redirect, squash, decode hold and stage enables for control-transfer ops
// Assumes: decode holds an instruction until this block is back in the run state
// Notes: every output is registered, so it acts in the cycle after the decision
// Overview of operation
// - untaken conditional branch takes one clock, next instruction decodes without stall
// - taken conditional branch takes two clocks, squashes sequential fetch, fetches target
// - taken branch after a status word writer takes three clocks
// - decode-resolved branches and jumps take target in decode, idle later stages
// - jump and link writes link register in write-back; plain branches write nothing
// - indirect jump resolves in execute, squashes two fetches, then fetches target
// - bit clear, invert, set do read-modify-write, two execute, two memory, no register
// - bit ops hold the next instruction two idle cycles before its decode
// - bit test does one memory read only, no register write, three clocks
// - table call runs fetch, decode, table read, execute, idle memory, idle write-back
// - table call return decodes in two cycles, reads saved pc, squashes two fetches
// - interrupt disable and enable never sample interrupts themselves
// - interrupt disable and enable do not stall, access memory or write registers
// - unconditional branch and relative jump skip write-back and always squash the next fetch
module bpc_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic id_valid,
  input wire logic [3:0] id_op,
  input wire logic id_cond_true,
  input wire logic id_psw_write,
  output logic fetch_squash,
  output logic fetch_redirect_id,
  output logic fetch_redirect_ex,
  output logic decode_hold,
  output logic mem_read,
  output logic mem_write,
  output logic table_read,
  output logic saved_pc_read,
  output logic wb_link_write,
  output logic irq_sample
);
  bpc_pkg::bpc_state_t state, next_state;
  logic rmw, next_rmw;
  logic wr_pend, next_wr_pend;
  logic jal_ex, next_jal_ex;
  logic jal_mem, next_jal_mem;
  logic prev_psw_write;
  logic id_accept;
  logic jal_accept;
  logic next_fetch_squash, next_fetch_redirect_id, next_fetch_redirect_ex;
  logic next_decode_hold, next_mem_read, next_mem_write, next_table_read;
  logic next_saved_pc_read, next_wb_link_write, next_irq_sample;

  assign id_accept = id_valid && (state == bpc_pkg::BPC_RUN);
  // plain signal so the link check can look back at it
  assign jal_accept = id_accept && (id_op == bpc_pkg::OP_JUMP_AND_LINK);

  bpc_psw_track i_bpc_psw_track (
    .clk(clk),
    .sys_rst(sys_rst),
    .id_accept(id_accept),
    .id_psw_write(id_psw_write),
    .prev_psw_write(prev_psw_write)
  );

  always_comb begin
    next_state = state;
    next_rmw = rmw;
    next_wr_pend = 1'b0;
    next_jal_ex = 1'b0;
    next_jal_mem = jal_ex;
    next_wb_link_write = jal_mem;
    next_mem_write = wr_pend;
    next_fetch_squash = 1'b0;
    next_fetch_redirect_id = 1'b0;
    next_fetch_redirect_ex = 1'b0;
    next_decode_hold = 1'b0;
    next_mem_read = 1'b0;
    next_table_read = 1'b0;
    next_saved_pc_read = 1'b0;
    next_irq_sample = 1'b0;
    unique case (state)
      bpc_pkg::BPC_RUN: begin
        if (id_valid) begin
          // sampling follows the instruction boundary, skipping the interrupt disable and enable ops
          next_irq_sample = !bpc_pkg::bpc_is_irq_op(id_op);
          next_rmw = bpc_pkg::bpc_is_rmw(id_op);
          if (id_op == bpc_pkg::OP_COND_BRANCH) begin
            if (id_cond_true && prev_psw_write) begin
              next_state = bpc_pkg::BPC_BR_FLAG;
              next_decode_hold = 1'b1;
            end else if (id_cond_true) begin
              next_fetch_redirect_id = 1'b1;
              next_fetch_squash = 1'b1;
            end
          end else if ((id_op == bpc_pkg::OP_REL_UNCOND_BRANCH) ||
                       (id_op == bpc_pkg::OP_RELATIVE_JUMP) ||
                       (id_op == bpc_pkg::OP_JUMP_AND_LINK)) begin
            next_fetch_redirect_id = 1'b1;
            next_fetch_squash = 1'b1;
            next_jal_ex = (id_op == bpc_pkg::OP_JUMP_AND_LINK);
          end else if (id_op == bpc_pkg::OP_REG_INDIRECT_JUMP) begin
            next_state = bpc_pkg::BPC_JMP_EX;
            next_fetch_squash = 1'b1;
          end else if (bpc_pkg::bpc_is_bit(id_op)) begin
            next_state = bpc_pkg::BPC_BIT_EX1;
            next_decode_hold = 1'b1;
          end else if (id_op == bpc_pkg::OP_TABLE_CALL) begin
            next_state = bpc_pkg::BPC_TC_MEM;
            next_table_read = 1'b1;
            next_fetch_squash = 1'b1;
            next_decode_hold = 1'b1;
          end else if (id_op == bpc_pkg::OP_TABLE_CALL_RETURN) begin
            next_state = bpc_pkg::BPC_TR_ID2;
            next_saved_pc_read = 1'b1;
            next_fetch_squash = 1'b1;
            next_decode_hold = 1'b1;
          end else if (bpc_pkg::bpc_is_irq_op(id_op)) begin
            // no hold and no memory slot, so the next op decodes right behind
            next_state = bpc_pkg::BPC_RUN;
          end
        end
      end
      bpc_pkg::BPC_BR_FLAG: begin
        next_fetch_redirect_id = 1'b1;
        next_fetch_squash = 1'b1;
        next_state = bpc_pkg::BPC_RUN;
      end
      bpc_pkg::BPC_JMP_EX: begin
        next_fetch_redirect_ex = 1'b1;
        next_fetch_squash = 1'b1;
        next_state = bpc_pkg::BPC_RUN;
      end
      bpc_pkg::BPC_BIT_EX1: begin
        next_mem_read = 1'b1;
        next_decode_hold = 1'b1;
        next_state = bpc_pkg::BPC_BIT_MEM1;
      end
      bpc_pkg::BPC_BIT_MEM1: begin
        // the test op leaves its second memory slot empty
        next_wr_pend = rmw;
        next_state = bpc_pkg::BPC_RUN;
      end
      bpc_pkg::BPC_TC_MEM: begin
        next_fetch_squash = 1'b1;
        next_decode_hold = 1'b1;
        next_state = bpc_pkg::BPC_TC_EX;
      end
      bpc_pkg::BPC_TC_EX: begin
        next_fetch_redirect_ex = 1'b1;
        next_fetch_squash = 1'b1;
        next_state = bpc_pkg::BPC_RUN;
      end
      bpc_pkg::BPC_TR_ID2: begin
        next_fetch_redirect_id = 1'b1;
        next_fetch_squash = 1'b1;
        next_state = bpc_pkg::BPC_RUN;
      end
      default: begin
        next_state = bpc_pkg::BPC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= bpc_pkg::BPC_RUN;
      rmw <= 1'b0;
      wr_pend <= 1'b0;
      jal_ex <= 1'b0;
      jal_mem <= 1'b0;
      fetch_squash <= 1'b0;
      fetch_redirect_id <= 1'b0;
      fetch_redirect_ex <= 1'b0;
      decode_hold <= 1'b0;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      table_read <= 1'b0;
      saved_pc_read <= 1'b0;
      wb_link_write <= 1'b0;
      irq_sample <= 1'b0;
    end else begin
      state <= next_state;
      rmw <= next_rmw;
      wr_pend <= next_wr_pend;
      jal_ex <= next_jal_ex;
      jal_mem <= next_jal_mem;
      fetch_squash <= next_fetch_squash;
      fetch_redirect_id <= next_fetch_redirect_id;
      fetch_redirect_ex <= next_fetch_redirect_ex;
      decode_hold <= next_decode_hold;
      mem_read <= next_mem_read;
      mem_write <= next_mem_write;
      table_read <= next_table_read;
      saved_pc_read <= next_saved_pc_read;
      wb_link_write <= next_wb_link_write;
      irq_sample <= next_irq_sample;
    end
  end

  // the assertions below watch the state machine against its decode inputs
  AST_UNTAKEN_NO_STALL: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && id_op == bpc_pkg::OP_COND_BRANCH && !id_cond_true)
      |=> (!decode_hold && !fetch_squash && state == bpc_pkg::BPC_RUN))
    else $error("untaken branch stalled");
  AST_TAKEN_TWO: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && id_op == bpc_pkg::OP_COND_BRANCH && id_cond_true && !prev_psw_write)
      |=> (fetch_redirect_id && fetch_squash))
    else $error("taken branch did not redirect next cycle");
  AST_FLAG_HAZARD: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && id_op == bpc_pkg::OP_COND_BRANCH && id_cond_true && prev_psw_write)
      |=> (!fetch_redirect_id && decode_hold) ##1 (fetch_redirect_id && fetch_squash))
    else $error("flag hazard branch not three clocks");
  AST_IND_JUMP: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && id_op == bpc_pkg::OP_REG_INDIRECT_JUMP)
      |=> (fetch_squash && !fetch_redirect_ex) ##1 (fetch_squash && fetch_redirect_ex))
    else $error("indirect jump squash or redirect wrong");
  AST_LINK_WB: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && id_op == bpc_pkg::OP_JUMP_AND_LINK) |=> ##2 wb_link_write)
    else $error("link write not in write-back");
  AST_NO_LINK_PLAIN: assert property (@(posedge clk) disable iff (sys_rst)
    wb_link_write |-> $past(jal_accept, 3))
    else $error("link write without jump and link");
  AST_RMW_SEQ: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && bpc_pkg::bpc_is_rmw(id_op))
      |=> decode_hold ##1 (decode_hold && mem_read) ##1 !decode_hold ##1 mem_write)
    else $error("read-modify-write sequence broken");
  AST_TEST_READ_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && id_op == bpc_pkg::OP_BIT_TEST) |=> ##1 mem_read ##1 !mem_write[*2])
    else $error("bit test wrote memory");
  AST_TCALL: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && id_op == bpc_pkg::OP_TABLE_CALL)
      |=> table_read ##1 (fetch_squash && !fetch_redirect_ex) ##1 fetch_redirect_ex)
    else $error("table call sequence broken");
  AST_TRET: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && id_op == bpc_pkg::OP_TABLE_CALL_RETURN)
      |=> (saved_pc_read && fetch_squash) ##1 (fetch_squash && fetch_redirect_id))
    else $error("table return sequence broken");
  AST_IRQ_OPS: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && bpc_pkg::bpc_is_irq_op(id_op)) |=> (!irq_sample && !decode_hold))
    else $error("interrupt op sampled or stalled");
  AST_IRQ_NO_STALL: assert property (@(posedge clk) disable iff (sys_rst)
    (id_accept && bpc_pkg::bpc_is_irq_op(id_op))
      |=> (state == bpc_pkg::BPC_RUN && !mem_read && !table_read && !saved_pc_read))
    else $error("interrupt op stalled or touched memory");
endmodule : bpc_ctrl

// *** common/bpc_pkg.sv ***
// Purpose: shared codes for the branch, bit-op and special-op pipeline control
// Assumes: decode presents one instruction class code per cycle
// Notes: class codes are fixed at four bits
package bpc_pkg;
  localparam int OP_W = 4;
  localparam logic [3:0] OP_OTHER = 4'h0;
  localparam logic [3:0] OP_COND_BRANCH = 4'h1;
  localparam logic [3:0] OP_REL_UNCOND_BRANCH = 4'h2;
  localparam logic [3:0] OP_JUMP_AND_LINK = 4'h3;
  localparam logic [3:0] OP_RELATIVE_JUMP = 4'h4;
  localparam logic [3:0] OP_REG_INDIRECT_JUMP = 4'h5;
  localparam logic [3:0] OP_BIT_CLEAR = 4'h6;
  localparam logic [3:0] OP_BIT_INVERT = 4'h7;
  localparam logic [3:0] OP_BIT_SET = 4'h8;
  localparam logic [3:0] OP_BIT_TEST = 4'h9;
  localparam logic [3:0] OP_TABLE_CALL = 4'hA;
  localparam logic [3:0] OP_TABLE_CALL_RETURN = 4'hB;
  localparam logic [3:0] OP_INTERRUPT_DISABLE = 4'hC;
  localparam logic [3:0] OP_INTERRUPT_ENABLE = 4'hD;

  typedef enum logic [7:0] {
    BPC_RUN = 8'h01,
    BPC_BR_FLAG = 8'h02,
    BPC_JMP_EX = 8'h04,
    BPC_BIT_EX1 = 8'h08,
    BPC_BIT_MEM1 = 8'h10,
    BPC_TC_MEM = 8'h20,
    BPC_TC_EX = 8'h40,
    BPC_TR_ID2 = 8'h80
  } bpc_state_t;

  function automatic logic bpc_is_rmw(input logic [3:0] op);
    return (op == OP_BIT_CLEAR) || (op == OP_BIT_INVERT) || (op == OP_BIT_SET);
  endfunction : bpc_is_rmw

  function automatic logic bpc_is_bit(input logic [3:0] op);
    return bpc_is_rmw(op) || (op == OP_BIT_TEST);
  endfunction : bpc_is_bit

  function automatic logic bpc_is_irq_op(input logic [3:0] op);
    return (op == OP_INTERRUPT_DISABLE) || (op == OP_INTERRUPT_ENABLE);
  endfunction : bpc_is_irq_op
endpackage : bpc_pkg

// *** design/bpc_psw_track.sv ***
// Purpose: remembers whether the last instruction to leave decode writes the status word
// Assumes: accept pulses once per instruction leaving decode
// Notes: only the immediately preceding instruction matters
module bpc_psw_track (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic id_accept,
  input wire logic id_psw_write,
  output logic prev_psw_write
);
  logic next_prev_psw_write;

  always_comb begin
    next_prev_psw_write = prev_psw_write;
    if (id_accept) begin
      next_prev_psw_write = id_psw_write;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_psw_write <= 1'b0;
    end else begin
      prev_psw_write <= next_prev_psw_write;
    end
  end
endmodule : bpc_psw_track

// *** bench/bpc_ctrl_test.sv ***
// Purpose: self-checking bench for the branch, bit-op and special-op pipeline control
// Assumes: registered outputs; inputs change on the falling edge
// Notes: held decode slots carry random ops, so refused requests get exercised too
module bpc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [10:0] SQ = 11'h200, RI = 11'h100, RE = 11'h080, HD = 11'h040;
  localparam logic [10:0] MR = 11'h020, MW = 11'h010, TR = 11'h008, SP = 11'h004;
  localparam logic [10:0] WL = 11'h002, IS = 11'h401, IC = 11'h400;
  logic clk, sys_rst, id_valid, id_cond_true, id_psw_write;
  logic [3:0] id_op;
  logic fetch_squash, fetch_redirect_id, fetch_redirect_ex, decode_hold, mem_read;
  logic mem_write, table_read, saved_pc_read, wb_link_write, irq_sample;
  // bit 10 marks a cycle whose interrupt sample is defined
  logic [10:0] pend [0:4];
  logic [10:0] notes [$];
  logic prev_psw;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;

  bpc_ctrl i_bpc_ctrl (.clk(clk), .sys_rst(sys_rst), .id_valid(id_valid), .id_op(id_op),
    .id_cond_true(id_cond_true), .id_psw_write(id_psw_write), .fetch_squash(fetch_squash),
    .fetch_redirect_id(fetch_redirect_id), .fetch_redirect_ex(fetch_redirect_ex),
    .decode_hold(decode_hold), .mem_read(mem_read), .mem_write(mem_write),
    .table_read(table_read), .saved_pc_read(saved_pc_read), .wb_link_write(wb_link_write),
    .irq_sample(irq_sample));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic step();
    notes.push_back(pend[0]);
    for (int i = 0; i < 4; i++) pend[i] = pend[i + 1];
    pend[4] = 11'h000;
    @(negedge clk);
  endtask : step

  task automatic issue(input logic [3:0] op, input logic cnd, input logic psw);
    int gap;
    logic [10:0] e [1:4];
    gap = 1;
    e = '{default: 11'h000};
    id_valid = 1'b1;
    id_op = op;
    id_cond_true = cnd;
    id_psw_write = psw;
    case (op)
      bpc_pkg::OP_OTHER: e[1] = IS;
      bpc_pkg::OP_COND_BRANCH: begin
        if (!cnd) e[1] = IS;
        else if (prev_psw) begin
          e[1] = HD;
          e[2] = SQ | RI;
          gap = 2;
        end else e[1] = SQ | RI | IS;
      end
      bpc_pkg::OP_REL_UNCOND_BRANCH, bpc_pkg::OP_RELATIVE_JUMP: e[1] = SQ | RI;
      bpc_pkg::OP_JUMP_AND_LINK: begin
        e[1] = SQ | RI;
        e[3] = WL;
      end
      bpc_pkg::OP_REG_INDIRECT_JUMP: begin
        e[1] = SQ;
        e[2] = SQ | RE;
        gap = 2;
      end
      bpc_pkg::OP_BIT_CLEAR, bpc_pkg::OP_BIT_INVERT, bpc_pkg::OP_BIT_SET,
      bpc_pkg::OP_BIT_TEST: begin
        e[1] = HD;
        e[2] = HD | MR;
        e[4] = (op == bpc_pkg::OP_BIT_TEST) ? 11'h000 : MW;
        gap = 3;
      end
      bpc_pkg::OP_TABLE_CALL: begin
        e[1] = TR | SQ | HD;
        e[2] = SQ | HD;
        e[3] = SQ | RE;
        gap = 3;
      end
      bpc_pkg::OP_TABLE_CALL_RETURN: begin
        e[1] = SP | SQ | HD;
        e[2] = SQ | RI;
        gap = 2;
      end
      default: e[1] = IC;
    endcase
    for (int j = 1; j <= 4; j++) pend[j - 1] = pend[j - 1] | e[j];
    prev_psw = psw;
    step();
    // refused slots still present a random op, which must never be taken
    for (int k = 1; k < gap; k++) begin
      id_op = 4'($urandom_range(13, 0));
      id_cond_true = 1'($urandom_range(1, 0));
      id_psw_write = 1'($urandom_range(1, 0));
      step();
    end
  endtask : issue

  initial begin
    logic [10:0] n;
    logic [9:0] got;
    forever begin
      @(posedge clk);
      #1;
      if (notes.size() > 0) begin
        n = notes.pop_front();
        got = {fetch_squash, fetch_redirect_id, fetch_redirect_ex, decode_hold, mem_read,
          mem_write, table_read, saved_pc_read, wb_link_write, irq_sample};
        n_compared++;
        if ((got[9:1] !== n[9:1]) || (n[10] && (got[0] !== n[0]))) begin
          bad_count++;
          $display("[ERR] %0t outputs %h expected %h", $time, got, n[9:0]);
        end
      end
    end
  end

  initial begin
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 5000) begin
        bad_count++;
        $display("[ERR] %0t timeout after %0d cycles", $time, cyc);
        close_out();
      end
    end
  end

  initial begin
    sys_rst = 1'b1;
    id_valid = 1'b0;
    id_op = bpc_pkg::OP_OTHER;
    id_cond_true = 1'b0;
    id_psw_write = 1'b0;
    prev_psw = 1'b0;
    pend = '{default: 11'h000};
    void'($urandom(32'h169F4EE0));
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    step();
    issue(bpc_pkg::OP_OTHER, 1'b0, 1'b1);
    issue(bpc_pkg::OP_COND_BRANCH, 1'b1, 1'b0);
    issue(bpc_pkg::OP_COND_BRANCH, 1'b0, 1'b1);
    issue(bpc_pkg::OP_COND_BRANCH, 1'b1, 1'b0);
    issue(bpc_pkg::OP_COND_BRANCH, 1'b1, 1'b0);
    issue(bpc_pkg::OP_REL_UNCOND_BRANCH, 1'b0, 1'b0);
    issue(bpc_pkg::OP_JUMP_AND_LINK, 1'b0, 1'b0);
    issue(bpc_pkg::OP_RELATIVE_JUMP, 1'b0, 1'b0);
    issue(bpc_pkg::OP_REG_INDIRECT_JUMP, 1'b0, 1'b0);
    issue(bpc_pkg::OP_BIT_CLEAR, 1'b0, 1'b0);
    issue(bpc_pkg::OP_BIT_INVERT, 1'b0, 1'b0);
    issue(bpc_pkg::OP_BIT_SET, 1'b0, 1'b0);
    issue(bpc_pkg::OP_BIT_TEST, 1'b0, 1'b0);
    issue(bpc_pkg::OP_TABLE_CALL, 1'b0, 1'b0);
    issue(bpc_pkg::OP_TABLE_CALL_RETURN, 1'b0, 1'b0);
    issue(bpc_pkg::OP_INTERRUPT_DISABLE, 1'b0, 1'b0);
    issue(bpc_pkg::OP_INTERRUPT_ENABLE, 1'b0, 1'b0);
    repeat (300) begin
      issue(4'($urandom_range(13, 0)), 1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)));
    end
    id_valid = 1'b0;
    repeat (6) step();
    close_out();
  end
endmodule : bpc_ctrl_test
